/* spw_pkg.sv */
/*
 * constants, field positions and types for the soft power wake-enable block.
 * assumes an 8-bit register port and active-low wake pins that idle high.
 */
package spw_pkg;

	// ***************************************
	// widths
	// ***************************************
	localparam int SPW_AW   = 8;
	localparam int SPW_DW   = 8;
	localparam int SPW_NPIN = 9;

	// ***************************************
	// register offsets
	// ***************************************
	localparam logic [SPW_AW-1:0] SPW_ADDR_EN_PRI  = 8'hB0;
	localparam logic [SPW_AW-1:0] SPW_ADDR_EN_SEC  = 8'hB1;
	localparam logic [SPW_AW-1:0] SPW_ADDR_STS_PRI = 8'hB2;
	localparam logic [SPW_AW-1:0] SPW_ADDR_STS_SEC = 8'hB3;
	localparam logic [SPW_AW-1:0] SPW_ADDR_MSK_PRI = 8'hBC;
	localparam logic [SPW_AW-1:0] SPW_ADDR_MSK_SEC = 8'hBD;

	// ***************************************
	// reset values and writable bits
	// ***************************************
	localparam logic [SPW_DW-1:0] SPW_RST_EN_PRI = 8'h00;
	localparam logic [SPW_DW-1:0] SPW_RST_EN_SEC = 8'h80;
	localparam logic [SPW_DW-1:0] SPW_RST_ZERO   = 8'h00;
	localparam logic [SPW_DW-1:0] SPW_WMSK_PRI   = 8'h7F;
	localparam logic [SPW_DW-1:0] SPW_WMSK_SEC   = 8'hDB;
	localparam logic [SPW_DW-1:0] SPW_WMSK_STS_P = 8'h4F;
	localparam logic [SPW_DW-1:0] SPW_WMSK_STS_S = 8'h0F;

	// ***************************************
	// primary enable / status bit positions
	// ***************************************
	localparam int SPW_B_RI1   = 0;
	localparam int SPW_B_RI2   = 1;
	localparam int SPW_B_KDAT  = 2;
	localparam int SPW_B_MDAT  = 3;
	localparam int SPW_B_GIRQ1 = 4;
	localparam int SPW_B_GIRQ2 = 5;
	localparam int SPW_B_IRRX2 = 6;

	// ***************************************
	// secondary enable / status bit positions
	// ***************************************
	localparam int SPW_B_RXD1    = 0;
	localparam int SPW_B_RXD2    = 1;
	localparam int SPW_B_BUTTON  = 2;
	localparam int SPW_B_RING    = 3;
	localparam int SPW_B_POR_OFF = 4;
	localparam int SPW_B_POR_ON  = 6;
	localparam int SPW_B_OFF_EN  = 7;

	// ***************************************
	// pin vector order
	// ***************************************
	localparam int SPW_P_RI1    = 0;
	localparam int SPW_P_RI2    = 1;
	localparam int SPW_P_KDAT   = 2;
	localparam int SPW_P_MDAT   = 3;
	localparam int SPW_P_IRRX2  = 4;
	localparam int SPW_P_RXD1   = 5;
	localparam int SPW_P_RXD2   = 6;
	localparam int SPW_P_RING   = 7;
	localparam int SPW_P_BUTTON = 8;
	localparam logic [SPW_NPIN-1:0] SPW_PIN_IDLE = 9'h1FF;

	typedef enum logic {
		SPW_PWR_OFF = 1'b0,
		SPW_PWR_ON  = 1'b1
	} spw_pwr_t;

endpackage

/* spw_sync.sv */
/*
 * two flip-flop synchroniser for a vector of asynchronous levels.
 * assumes the bits are independent; no bus coherence is given.
 */
`timescale 1ns/10ps
module spw_sync #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);

	logic [W-1:0] meta_ff;

	// first stage is read only by the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= INIT;
			q       <= INIT;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule

/* spw_fall_latch.sv */
/*
 * per-bit high-to-low detector with sticky flags, cleared per bit.
 * assumes inputs are already synchronised to clock.
 */
`timescale 1ns/10ps
module spw_fall_latch #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    IDLE = '1
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic [W-1:0]  level,
	input  wire logic [W-1:0]  arm,
	input  wire logic [W-1:0]  clr,
	output logic      [W-1:0]  fall,
	output logic      [W-1:0]  sticky
);

	logic [W-1:0] prev_ff;
	logic [W-1:0] sticky_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= IDLE;
		end else begin
			prev_ff <= level;
		end
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		// disabled sources neither wake nor flag
		assign fall[i] = prev_ff[i] & ~level[i] & arm[i];
		// a new edge in the clearing cycle survives
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				sticky_ff[i] <= 1'b0;
			end else begin
				sticky_ff[i] <= (sticky_ff[i] & ~clr[i]) | fall[i];
			end
		end
	end

	assign sticky = sticky_ff;

endmodule

/* spw_soft_power_wake.sv */
/*
 * soft power wake-enable block: enable registers, wake latches, power-on
 * output control, standby-reset handling and a status interrupt.
 * assumes one 40 MHz clock, rst_n from the battery-backed power-on reset,
 * wake pins and button asynchronous and idle high, group interrupts and
 * the standby-reset pulse produced elsewhere.
 */
`timescale 1ns/10ps

// What this block does
// - an enable bit of one lets its source turn power on; zero ignores it
// - primary enable: ring indicators, keyboard, mouse, group irqs, infrared; bit 7 reserved
// - secondary enable bits 0 and 1 take uart receive data; bits 2, 5 reserved
// - secondary bit 3 lets the dedicated ring input wake the machine
// - power-off bit set: standby reset floats the power-on output inactive
// - power-on bit set, power-off bit clear: standby reset drives the power-on output low three clock edges after the rise
// - both standby-reset bits clear: power-on output keeps its earlier state
// - secondary bit 7 lets the button switch power off; resets to one
// - latched sources flag a falling edge, held until the status read
module spw_soft_power_wake
	import spw_pkg::*;
(
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic [spw_pkg::SPW_AW-1:0] addr,
	input  wire logic [spw_pkg::SPW_DW-1:0] wr_data,
	input  wire logic                      wr_stb,
	input  wire logic                      rd_stb,
	output logic      [spw_pkg::SPW_DW-1:0] rd_data,
	input  wire logic                      uart1_ring_n,
	input  wire logic                      uart2_ring_n,
	input  wire logic                      keyboard_data,
	input  wire logic                      mouse_data,
	input  wire logic                      infrared_rx2,
	input  wire logic                      uart1_rxd,
	input  wire logic                      uart2_rxd,
	input  wire logic                      ring_input_n,
	input  wire logic                      power_button_n,
	input  wire logic                      group_irq1,
	input  wire logic                      group_irq2,
	input  wire logic                      standby_supply_por,
	output logic                           power_on_request_n,
	output logic                           power_on_request_oe,
	output logic                           power_is_on,
	output logic                           irq
);
	import spw_pkg::*;

	// ***************************************
	// reset release
	// ***************************************
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ***************************************
	// pin synchronisers
	// ***************************************
	logic [SPW_NPIN-1:0] pin_raw;
	logic [SPW_NPIN-1:0] pin_sync;
	logic                por_sync;
	logic                por_prev_ff;
	logic                por_pulse;

	assign pin_raw[SPW_P_RI1]    = uart1_ring_n;
	assign pin_raw[SPW_P_RI2]    = uart2_ring_n;
	assign pin_raw[SPW_P_KDAT]   = keyboard_data;
	assign pin_raw[SPW_P_MDAT]   = mouse_data;
	assign pin_raw[SPW_P_IRRX2]  = infrared_rx2;
	assign pin_raw[SPW_P_RXD1]   = uart1_rxd;
	assign pin_raw[SPW_P_RXD2]   = uart2_rxd;
	assign pin_raw[SPW_P_RING]   = ring_input_n;
	assign pin_raw[SPW_P_BUTTON] = power_button_n;

	// idle-high reset value avoids a false edge after reset
	spw_sync #(
		.W    (SPW_NPIN),
		.INIT (SPW_PIN_IDLE)
	) u_pin_sync (
		.clock (clock),
		.rst_n (rst_sync_ff),
		.d     (pin_raw),
		.q     (pin_sync)
	);

	spw_sync #(
		.W    (1),
		.INIT (1'b0)
	) u_por_sync (
		.clock (clock),
		.rst_n (rst_sync_ff),
		.d     (standby_supply_por),
		.q     (por_sync)
	);

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			por_prev_ff <= 1'b0;
		end else begin
			por_prev_ff <= por_sync;
		end
	end

	assign por_pulse = por_sync & ~por_prev_ff;

	// ***************************************
	// enable registers
	// ***************************************
	logic [SPW_DW-1:0] en_pri_ff;
	logic [SPW_DW-1:0] en_sec_ff;
	logic [SPW_DW-1:0] msk_pri_ff;
	logic [SPW_DW-1:0] msk_sec_ff;
	logic              wr_en_pri;
	logic              wr_en_sec;
	logic              wr_msk_pri;
	logic              wr_msk_sec;

	assign wr_en_pri  = wr_stb && (addr == SPW_ADDR_EN_PRI);
	assign wr_en_sec  = wr_stb && (addr == SPW_ADDR_EN_SEC);
	assign wr_msk_pri = wr_stb && (addr == SPW_ADDR_MSK_PRI);
	assign wr_msk_sec = wr_stb && (addr == SPW_ADDR_MSK_SEC);

	// reserved bit 7 never stores
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			en_pri_ff <= SPW_RST_EN_PRI;
		end else if (wr_en_pri) begin
			en_pri_ff <= wr_data & SPW_WMSK_PRI;
		end
	end

	// off-enable resets to one; reserved bits 2 and 5 never store
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			en_sec_ff <= SPW_RST_EN_SEC;
		end else if (wr_en_sec) begin
			en_sec_ff <= wr_data & SPW_WMSK_SEC;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			msk_pri_ff <= SPW_RST_ZERO;
		end else if (wr_msk_pri) begin
			msk_pri_ff <= wr_data;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			msk_sec_ff <= SPW_RST_ZERO;
		end else if (wr_msk_sec) begin
			msk_sec_ff <= wr_data;
		end
	end

	// ***************************************
	// wake source latching
	// ***************************************
	logic [SPW_NPIN-1:0] src_arm;
	logic [SPW_NPIN-1:0] src_clr;
	logic [SPW_NPIN-1:0] src_fall;
	logic [SPW_NPIN-1:0] src_sticky;
	logic                rd_sts_pri;
	logic                rd_sts_sec;

	assign rd_sts_pri = rd_stb && (addr == SPW_ADDR_STS_PRI);
	assign rd_sts_sec = rd_stb && (addr == SPW_ADDR_STS_SEC);

	// each pin but the button is armed by its own enable bit; the button is always armed
	assign src_arm[SPW_P_RI1]    = en_pri_ff[SPW_B_RI1];
	assign src_arm[SPW_P_RI2]    = en_pri_ff[SPW_B_RI2];
	assign src_arm[SPW_P_KDAT]   = en_pri_ff[SPW_B_KDAT];
	assign src_arm[SPW_P_MDAT]   = en_pri_ff[SPW_B_MDAT];
	assign src_arm[SPW_P_IRRX2]  = en_pri_ff[SPW_B_IRRX2];
	assign src_arm[SPW_P_RXD1]   = en_sec_ff[SPW_B_RXD1];
	assign src_arm[SPW_P_RXD2]   = en_sec_ff[SPW_B_RXD2];
	assign src_arm[SPW_P_RING]   = en_sec_ff[SPW_B_RING];
	assign src_arm[SPW_P_BUTTON] = 1'b1;

	assign src_clr[SPW_P_RI1]    = rd_sts_pri;
	assign src_clr[SPW_P_RI2]    = rd_sts_pri;
	assign src_clr[SPW_P_KDAT]   = rd_sts_pri;
	assign src_clr[SPW_P_MDAT]   = rd_sts_pri;
	assign src_clr[SPW_P_IRRX2]  = rd_sts_pri;
	assign src_clr[SPW_P_RXD1]   = rd_sts_sec;
	assign src_clr[SPW_P_RXD2]   = rd_sts_sec;
	assign src_clr[SPW_P_RING]   = rd_sts_sec;
	assign src_clr[SPW_P_BUTTON] = rd_sts_sec;

	spw_fall_latch #(
		.W    (SPW_NPIN),
		.IDLE (SPW_PIN_IDLE)
	) u_latch (
		.clock  (clock),
		.rst_n  (rst_sync_ff),
		.level  (pin_sync),
		.arm    (src_arm),
		.clr    (src_clr),
		.fall   (src_fall),
		.sticky (src_sticky)
	);

	// ***************************************
	// wake event combine
	// ***************************************
	logic group_wake;
	logic pin_wake;
	logic wake_event;
	logic button_press;

	// group interrupts are levels; they are not latched here
	assign group_wake = (group_irq1 & en_pri_ff[SPW_B_GIRQ1]) |
	                    (group_irq2 & en_pri_ff[SPW_B_GIRQ2]);
	assign pin_wake   = |src_fall[SPW_P_RING:SPW_P_RI1];
	assign wake_event = pin_wake | group_wake;
	assign button_press = src_fall[SPW_P_BUTTON];

	// ***************************************
	// power state
	// ***************************************
	spw_pwr_t pwr_ff;
	spw_pwr_t nxt_pwr;
	logic     por_off;
	logic     por_on;

	assign por_off = en_sec_ff[SPW_B_POR_OFF];
	assign por_on  = en_sec_ff[SPW_B_POR_ON];

	// standby reset outranks wake events; if software breaks the
	// one-bit-only promise the off choice wins, the safer of the two
	always_comb begin
		nxt_pwr = pwr_ff;
		if (por_pulse) begin
			if (por_off) begin
				nxt_pwr = SPW_PWR_OFF;
			end else if (por_on) begin
				nxt_pwr = SPW_PWR_ON;
			end else begin
				nxt_pwr = pwr_ff;
			end
		end else begin
			unique case (pwr_ff)
				SPW_PWR_OFF: begin
					if (wake_event || button_press) begin
						nxt_pwr = SPW_PWR_ON;
					end
				end
				SPW_PWR_ON: begin
					if (button_press && en_sec_ff[SPW_B_OFF_EN]) begin
						nxt_pwr = SPW_PWR_OFF;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pwr_ff <= SPW_PWR_OFF;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	// ***************************************
	// power-on pin
	// ***************************************
	// open drain: driven low while on, floated while off;
	// outputs track the next state so the pin moves with the state
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			power_on_request_n  <= 1'b1;
			power_on_request_oe <= 1'b0;
			power_is_on         <= 1'b0;
		end else begin
			power_on_request_n  <= (nxt_pwr != SPW_PWR_ON);
			power_on_request_oe <= (nxt_pwr == SPW_PWR_ON);
			power_is_on         <= (nxt_pwr == SPW_PWR_ON);
		end
	end

	// ***************************************
	// status registers
	// ***************************************
	logic [SPW_DW-1:0] sts_pri;
	logic [SPW_DW-1:0] sts_sec;
	logic [SPW_DW-1:0] girq_ff;

	// group interrupt bits are live, cleared at their source
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			girq_ff <= SPW_RST_ZERO;
		end else begin
			girq_ff                <= SPW_RST_ZERO;
			girq_ff[SPW_B_GIRQ1]   <= group_irq1 & en_pri_ff[SPW_B_GIRQ1];
			girq_ff[SPW_B_GIRQ2]   <= group_irq2 & en_pri_ff[SPW_B_GIRQ2];
		end
	end

	always_comb begin
		sts_pri                 = girq_ff;
		sts_pri[SPW_B_RI1]      = src_sticky[SPW_P_RI1];
		sts_pri[SPW_B_RI2]      = src_sticky[SPW_P_RI2];
		sts_pri[SPW_B_KDAT]     = src_sticky[SPW_P_KDAT];
		sts_pri[SPW_B_MDAT]     = src_sticky[SPW_P_MDAT];
		sts_pri[SPW_B_IRRX2]    = src_sticky[SPW_P_IRRX2];
	end

	always_comb begin
		sts_sec                 = SPW_RST_ZERO;
		sts_sec[SPW_B_RXD1]     = src_sticky[SPW_P_RXD1];
		sts_sec[SPW_B_RXD2]     = src_sticky[SPW_P_RXD2];
		sts_sec[SPW_B_BUTTON]   = src_sticky[SPW_P_BUTTON];
		sts_sec[SPW_B_RING]     = src_sticky[SPW_P_RING];
	end

	// ***************************************
	// interrupt
	// ***************************************
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			irq <= 1'b0;
		end else begin
			irq <= (|(sts_pri & msk_pri_ff)) | (|(sts_sec & msk_sec_ff));
		end
	end

	// ***************************************
	// read port
	// ***************************************
	// data is held only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			rd_data <= SPW_RST_ZERO;
		end else if (!rd_stb) begin
			rd_data <= SPW_RST_ZERO;
		end else begin
			unique case (addr)
				SPW_ADDR_EN_PRI:  rd_data <= en_pri_ff;
				SPW_ADDR_EN_SEC:  rd_data <= en_sec_ff;
				SPW_ADDR_STS_PRI: rd_data <= sts_pri;
				SPW_ADDR_STS_SEC: rd_data <= sts_sec;
				SPW_ADDR_MSK_PRI: rd_data <= msk_pri_ff;
				SPW_ADDR_MSK_SEC: rd_data <= msk_sec_ff;
				default:          rd_data <= SPW_RST_ZERO;
			endcase
		end
	end

endmodule

/* spw_supply_model.sv */
/*
 * far-side model: wake-source pins and the system supply switch.
 * assumes the supply line has a pull-up, so a floated request reads as off.
 */
`timescale 1ns/10ps
module spw_supply_model (
	input  wire logic                          clock,
	input  wire logic                          power_on_request_n,
	input  wire logic                          power_on_request_oe,
	output logic      [spw_pkg::SPW_NPIN-1:0]  pin,
	output logic                               supply_on
);
	import spw_pkg::*;
	logic line_level;

	// ***************************************
	// supply switch
	// ***************************************
	initial pin = SPW_PIN_IDLE;
	// released line goes to the pull-up level, never the last driven value
	assign line_level = power_on_request_oe ? power_on_request_n : 1'b1;
	assign supply_on  = !line_level;

	// ***************************************
	// wake pins
	// ***************************************
	// one low pulse; the event is the fall, the rise is harmless
	task automatic pulse(input int idx, input int len);
		@(posedge clock);
		pin[idx] <= 1'b0;
		repeat (len) @(posedge clock);
		pin[idx] <= 1'b1;
	endtask
endmodule

/* spw_soft_power_wake_chk.sv */
/*
 * concurrent checks on the wake-enable block ports.
 * assumes bench keeps one wake source active at a time.
 */
`timescale 1ns/10ps
module spw_soft_power_wake_chk (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	input  wire logic [7:0]  rd_data,
	input  wire logic        keyboard_data,
	input  wire logic        uart1_rxd,
	input  wire logic        ring_input_n,
	input  wire logic        power_button_n,
	input  wire logic        group_irq1,
	input  wire logic        standby_supply_por,
	input  wire logic        power_on_request_n,
	input  wire logic        power_on_request_oe,
	input  wire logic        power_is_on
);
	import spw_pkg::*;
	logic [7:0] en_pri_ff;
	logic [7:0] en_sec_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ***************************************
	// enable shadows
	// ***************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_pri_ff <= 8'h00;
		end else if (wr_stb && addr == SPW_ADDR_EN_PRI) begin
			en_pri_ff <= wr_data & 8'h7F;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_sec_ff <= 8'h80;
		end else if (wr_stb && addr == SPW_ADDR_EN_SEC) begin
			en_sec_ff <= wr_data & 8'hDB;
		end
	end

	// ***************************************
	// power outcomes, three edges after a pin fall or standby-reset rise (two sync flops); group wake one edge after the level
	// ***************************************
	sequence up_after3;
		##3 (power_is_on && power_on_request_oe && !power_on_request_n);
	endsequence
	sequence down_after3;
		##3 (!power_is_on && !power_on_request_oe && power_on_request_n);
	endsequence
	sequence por_rise;
		$rose(standby_supply_por);
	endsequence

	chk_kbd_wake: assert property (($fell(keyboard_data) && en_pri_ff[SPW_B_KDAT] && !power_is_on) |-> up_after3)
		else $error("keyboard wake missed");
	chk_kbd_ignored: assert property (($fell(keyboard_data) && !en_pri_ff[SPW_B_KDAT] && !power_is_on && !group_irq1)
		|-> ##3 !power_is_on) else $error("disabled keyboard woke");
	chk_rx_wake: assert property (($fell(uart1_rxd) && en_sec_ff[SPW_B_RXD1] && !power_is_on) |-> up_after3)
		else $error("receive data wake missed");
	chk_ring_wake: assert property (($fell(ring_input_n) && en_sec_ff[SPW_B_RING] && !power_is_on) |-> up_after3)
		else $error("ring wake missed");
	chk_group_wake: assert property ((group_irq1 && en_pri_ff[SPW_B_GIRQ1] && !power_is_on) |=> power_is_on)
		else $error("group wake missed");
	chk_por_off: assert property ((por_rise and en_sec_ff[SPW_B_POR_OFF]) |-> down_after3)
		else $error("standby reset did not float output");
	chk_por_on: assert property ((por_rise and (!en_sec_ff[SPW_B_POR_OFF] && en_sec_ff[SPW_B_POR_ON])) |-> up_after3)
		else $error("standby reset did not power up");
	chk_por_keep: assert property ((por_rise and (en_sec_ff[6:4] == 3'b000))
		|-> ##3 (power_is_on == $past(power_is_on, 3))) else $error("standby reset changed power");
	chk_button_hold: assert property (($fell(power_button_n) && !en_sec_ff[SPW_B_OFF_EN] && power_is_on)
		|-> ##3 power_is_on) else $error("button off not blocked");
	chk_button_off: assert property (($fell(power_button_n) && en_sec_ff[SPW_B_OFF_EN] && power_is_on) |-> down_after3)
		else $error("button off missed");
	chk_sec_readback: assert property ((rd_stb && addr == SPW_ADDR_EN_SEC) |=> rd_data == $past(en_sec_ff))
		else $error("secondary enable readback");
	chk_pri_readback: assert property ((rd_stb && addr == SPW_ADDR_EN_PRI) |=> rd_data == $past(en_pri_ff))
		else $error("primary enable readback");
endmodule

bind spw_soft_power_wake spw_soft_power_wake_chk u_chk (
	.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rd_data(rd_data), .keyboard_data(keyboard_data), .uart1_rxd(uart1_rxd), .ring_input_n(ring_input_n),
	.power_button_n(power_button_n), .group_irq1(group_irq1), .standby_supply_por(standby_supply_por),
	.power_on_request_n(power_on_request_n), .power_on_request_oe(power_on_request_oe), .power_is_on(power_is_on)
);

/* tb_spw_soft_power_wake.sv */
/*
 * self-checking bench for the wake-enable block against an integer model.
 * assumes the far-side model drives the pins and reads the supply line.
 */
`timescale 1ns/10ps
module tb_spw_soft_power_wake;
	import spw_pkg::*;
	localparam int LIMIT = 20000;
	logic                clock   = 1'b0;
	logic                rst_n   = 1'b0;
	logic [SPW_AW-1:0]   addr    = 8'h00;
	logic [SPW_DW-1:0]   wr_data = 8'h00;
	logic                wr_stb  = 1'b0;
	logic                rd_stb  = 1'b0;
	logic [1:0]          grp     = 2'b00;
	logic                por     = 1'b0;
	logic [SPW_DW-1:0]   rd_data;
	logic [SPW_NPIN-1:0] pin;
	logic                req_n;
	logic                req_oe;
	logic                is_on;
	logic                irq;
	logic                supply_on;
	logic [31:0]         seed    = 32'hB698;
	int                  errors  = 0;
	int                  check_count = 0;
	int                  cycles  = 0;
	int                  en_m[2] = '{0, 8'h80};
	int                  sts_m[2] = '{0, 0};
	int                  msk_m[2] = '{0, 0};
	int                  pwr_m   = 0;
	int                  map_reg[9] = '{0, 0, 0, 0, 0, 1, 1, 1, 1};
	int                  map_bit[9] = '{0, 1, 2, 3, 6, 0, 1, 3, 2};
	logic [7:0]          por_cfg[3] = '{8'h90, 8'hC0, 8'h80};

	always #12.5 clock = ~clock;

	spw_soft_power_wake dut (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rd_data(rd_data), .uart1_ring_n(pin[SPW_P_RI1]), .uart2_ring_n(pin[SPW_P_RI2]),
		.keyboard_data(pin[SPW_P_KDAT]), .mouse_data(pin[SPW_P_MDAT]), .infrared_rx2(pin[SPW_P_IRRX2]),
		.uart1_rxd(pin[SPW_P_RXD1]), .uart2_rxd(pin[SPW_P_RXD2]), .ring_input_n(pin[SPW_P_RING]),
		.power_button_n(pin[SPW_P_BUTTON]), .group_irq1(grp[0]), .group_irq2(grp[1]),
		.standby_supply_por(por), .power_on_request_n(req_n), .power_on_request_oe(req_oe),
		.power_is_on(is_on), .irq(irq)
	);
	spw_supply_model far (
		.clock(clock), .power_on_request_n(req_n), .power_on_request_oe(req_oe), .pin(pin),
		.supply_on(supply_on)
	);

	// ***************************************
	// helpers
	// ***************************************
	function automatic logic [7:0] rnd8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr    <= a;
		wr_data <= d;
		wr_stb  <= 1'b1;
		@(posedge clock);
		wr_stb  <= 1'b0;
		case (a)
			SPW_ADDR_EN_PRI: en_m[0] = d & 8'h7F;
			SPW_ADDR_EN_SEC: en_m[1] = d & 8'hDB;
			SPW_ADDR_MSK_PRI: msk_m[0] = d;
			SPW_ADDR_MSK_SEC: msk_m[1] = d;
			default: ;
		endcase
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 check(rd_data, exp);
	endtask
	// a status read returns the latched flags and clears them
	task automatic rds(input int r, input logic [7:0] live);
		rdc(r ? SPW_ADDR_STS_SEC : SPW_ADDR_STS_PRI, 8'(sts_m[r]) | live);
		sts_m[r] = 0;
	endtask
	task automatic chk_pwr();
		#1 check({4'h0, req_n, is_on, req_oe, supply_on}, {4'h0, !pwr_m[0], {3{pwr_m[0]}}});
	endtask
	task automatic fire(input int p);
		far.pulse(p, int'(rnd8() % 8) + 1);
		if (p == SPW_P_BUTTON) begin
			sts_m[1] |= 4;
			pwr_m = int'(!pwr_m || !en_m[1][7]);
		end else if (en_m[map_reg[p]][map_bit[p]]) begin
			sts_m[map_reg[p]] |= 1 << map_bit[p];
			pwr_m = 1;
		end
		repeat (5) @(posedge clock);
		chk_pwr();
		check({7'h0, irq}, {7'h0, |((sts_m[0] & msk_m[0]) | (sts_m[1] & msk_m[1]))});
	endtask
	task automatic set_pwr(input int w);
		if (pwr_m != w) fire(SPW_P_BUTTON);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ***************************************
	// hang guard
	// ***************************************
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			results();
		end
	end

	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk_pwr();
		rdc(SPW_ADDR_EN_PRI, 8'h00);
		rdc(SPW_ADDR_EN_SEC, 8'h80);
		rdc(SPW_ADDR_STS_SEC, 8'h00);
		wr(8'h55, 8'hFF);
		rdc(8'h55, 8'h00);
		wr(SPW_ADDR_EN_PRI, 8'hFF);
		rdc(SPW_ADDR_EN_PRI, 8'h7F);
		wr(SPW_ADDR_EN_SEC, 8'hAF);
		rdc(SPW_ADDR_EN_SEC, 8'h8B);
		// random enables, masks, power state and source; both standby bits stay clear
		for (int i = 0; i < 80; i++) begin
			wr(SPW_ADDR_EN_SEC, 8'h80);
			set_pwr(int'(rnd8() % 2));
			wr(SPW_ADDR_EN_PRI, rnd8());
			wr(SPW_ADDR_EN_SEC, rnd8() & 8'h8B);
			wr(SPW_ADDR_MSK_PRI, rnd8());
			wr(SPW_ADDR_MSK_SEC, rnd8());
			fire(int'(rnd8() % 9));
			rds(0, 8'h00);
			rds(1, 8'h00);
		end
		// directed pass: every pin source assertion meets its trigger at least once
		for (int s = 0; s < 3; s++) begin
			wr(SPW_ADDR_EN_SEC, 8'h80);
			set_pwr(0);
			wr(SPW_ADDR_EN_PRI, 8'h00);
			fire(SPW_P_KDAT);
			wr(SPW_ADDR_EN_PRI, 8'h04);
			wr(SPW_ADDR_EN_SEC, 8'h0B);
			fire(s == 0 ? SPW_P_KDAT : (s == 1 ? SPW_P_RXD1 : SPW_P_RING));
			fire(SPW_P_BUTTON);
			rds(0, 8'h00);
			rds(1, 8'h00);
		end
		wr(SPW_ADDR_EN_SEC, 8'h80);
		wr(SPW_ADDR_EN_PRI, 8'h30);
		for (int g = 0; g < 2; g++) begin
			set_pwr(0);
			grp[g] <= 1'b1;
			repeat (3) @(posedge clock);
			pwr_m = 1;
			chk_pwr();
			rds(0, 8'h10 << g);
			grp <= 2'b00;
			repeat (2) @(posedge clock);
		end
		for (int k = 0; k < 6; k++) begin
			set_pwr(k % 2);
			wr(SPW_ADDR_EN_SEC, por_cfg[k / 2]);
			por <= 1'b1;
			repeat (4) @(posedge clock);
			por <= 1'b0;
			if (en_m[1][4]) pwr_m = 0;
			else if (en_m[1][6]) pwr_m = 1;
			chk_pwr();
		end
		results();
	end
endmodule
